// ---- adc_cfg_pkg.sv ----
// Constants, types and decode functions for the converter trigger config
package adc_cfg_pkg;

  localparam logic [7:0] CTRL_ONE_OFS = 8'h01;
  localparam logic [7:0] CTRL_TWO_OFS = 8'h02;
  localparam logic [7:0] STATUS_OFS   = 8'h03;

  localparam int TRIG_SRC_BIT = 7;
  localparam int WIDTH_HI_BIT = 6;
  localparam int WIDTH_LO_BIT = 5;
  localparam int DISCH_BIT    = 4;
  localparam int CHAN_HI_BIT  = 3;
  localparam int CHAN_LO_BIT  = 0;

  localparam int ST_LEVEL_BIT = 0;
  localparam int ST_TRSV_BIT  = 1;
  localparam int ST_WRSV_BIT  = 2;
  localparam int ST_EXT_BIT   = 3;

  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] RDATA_IDLE   = 8'h00;

  localparam int         ANALOG_CHANS  = 12;
  localparam int         EXT_TRIGS     = 4;
  localparam logic [3:0] LAST_ANALOG   = 4'hB;
  localparam logic [3:0] DISCH_EXTRA   = 4'h2;
  localparam logic [3:0] NO_EXTRA      = 4'h0;

  localparam int         REF_SPAN_MV   = 5120;
  localparam logic [4:0] STEP_MV_8     = 5'(REF_SPAN_MV / 256);
  localparam logic [4:0] STEP_MV_10    = 5'(REF_SPAN_MV / 1024);
  localparam logic [3:0] BITS_8        = 4'h8;
  localparam logic [3:0] BITS_10       = 4'hA;

  typedef enum logic [1:0] {
    WIDTH_8     = 2'h0,
    WIDTH_10    = 2'h1,
    WIDTH_RSV_A = 2'h2,
    WIDTH_RSV_B = 2'h3
  } result_width_t;

  function automatic logic [3:0] analog_index(input logic [3:0] chan);
    analog_index = (chan > LAST_ANALOG) ? LAST_ANALOG : chan;
  endfunction : analog_index

  function automatic logic chan_reserved(input logic [3:0] chan);
    chan_reserved = chan[3] | chan[2];
  endfunction : chan_reserved

endpackage : adc_cfg_pkg

// ---- trig_sel_if.sv ----
// Carrier between the register block and the trigger source mux
`timescale 1ns/1ns
`default_nettype none
interface trig_sel_if;
  logic       src_sel;
  logic [3:0] chan_sel;
  logic       level;
  logic       reserved;
  logic       ext_active;

  modport ctrl (output src_sel, chan_sel, input level, reserved, ext_active);
  modport mux  (input src_sel, chan_sel, output level, reserved, ext_active);
endinterface : trig_sel_if
`default_nettype wire

// ---- trig_source_mux.sv ----
// Synchronises trigger pins and picks the configured trigger source
`timescale 1ns/1ns
`default_nettype none
module trig_source_mux #(
  parameter bit EXT_TRIG_PRESENT = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [11:0] analog_trig_i,
  input  wire logic [3:0]  ext_trigger_in_i,
  trig_sel_if.mux          sel
);

  logic [11:0] an_s1_reg;
  logic [11:0] an_s2_reg;
  logic [3:0]  ext_s1_reg;
  logic [3:0]  ext_s2_reg;
  logic        level_reg;
  logic        rsv_reg;
  logic        eff_ext;
  logic        chan_rsv;
  logic        level_next;
  logic [3:0]  an_idx;

  // Without the dedicated inputs the select bit is only stored
  assign eff_ext  = EXT_TRIG_PRESENT & sel.src_sel;
  assign chan_rsv = eff_ext & adc_cfg_pkg::chan_reserved(sel.chan_sel);
  assign an_idx   = adc_cfg_pkg::analog_index(sel.chan_sel);
  // Reserved codes give a quiet trigger rather than an arbitrary pin
  assign level_next = chan_rsv ? 1'b0 :
                      eff_ext  ? ext_s2_reg[sel.chan_sel[1:0]] :
                                 an_s2_reg[an_idx];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      an_s1_reg  <= 12'h000;
      an_s2_reg  <= 12'h000;
      ext_s1_reg <= 4'h0;
      ext_s2_reg <= 4'h0;
      level_reg  <= 1'b0;
      rsv_reg    <= 1'b0;
    end else begin
      an_s1_reg  <= analog_trig_i;
      an_s2_reg  <= an_s1_reg;
      ext_s1_reg <= ext_trigger_in_i;
      ext_s2_reg <= ext_s1_reg;
      level_reg  <= level_next;
      rsv_reg    <= chan_rsv;
    end
  end

  assign sel.level      = level_reg;
  assign sel.reserved   = rsv_reg;
  assign sel.ext_active = eff_ext;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_analog_pick;
    !eff_ext |=> level_reg == $past(an_s2_reg[an_idx]);
  endproperty
  a_analog_pick: assert property (p_analog_pick)
    else $error("analog trigger channel not followed");

  property p_ext_pick;
    (eff_ext && !chan_rsv) |=>
      level_reg == $past(ext_s2_reg[sel.chan_sel[1:0]]);
  endproperty
  a_ext_pick: assert property (p_ext_pick)
    else $error("dedicated trigger input not followed");

  property p_rsv_quiet;
    chan_rsv |=> (!level_reg && rsv_reg);
  endproperty
  a_rsv_quiet: assert property (p_rsv_quiet)
    else $error("reserved trigger code not quiet");

  property p_absent_ignored;
    (!EXT_TRIG_PRESENT && sel.src_sel) |=>
      (level_reg == $past(an_s2_reg[an_idx]) && !rsv_reg);
  endproperty
  a_absent_ignored: assert property (p_absent_ignored)
    else $error("select bit acted without dedicated inputs");

  c_ext_used: cover property (eff_ext && !chan_rsv ##1 level_reg);

endmodule : trig_source_mux
`default_nettype wire

// ---- result_format.sv ----
// Decodes the result width code into result bits and step size
`timescale 1ns/1ns
`default_nettype none
module result_format (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] width_code_i,
  output logic      [3:0] result_bits_o,
  output logic      [4:0] step_mv_o,
  output logic            width_reserved_o
);

  adc_cfg_pkg::result_width_t code;
  logic [3:0] bits_next;
  logic [4:0] step_next;
  logic       rsv_next;
  logic [3:0] bits_reg;
  logic [4:0] step_reg;
  logic       rsv_reg;

  assign code = adc_cfg_pkg::result_width_t'(width_code_i);

  always_comb begin
    bits_next = adc_cfg_pkg::BITS_8;
    step_next = adc_cfg_pkg::STEP_MV_8;
    rsv_next  = 1'b0;
    case (code)
      adc_cfg_pkg::WIDTH_8: begin
        bits_next = adc_cfg_pkg::BITS_8;
        step_next = adc_cfg_pkg::STEP_MV_8;
      end
      adc_cfg_pkg::WIDTH_10: begin
        bits_next = adc_cfg_pkg::BITS_10;
        step_next = adc_cfg_pkg::STEP_MV_10;
      end
      // Reserved codes fall back to 8-bit data and are flagged
      default: begin
        rsv_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bits_reg <= adc_cfg_pkg::BITS_8;
      step_reg <= adc_cfg_pkg::STEP_MV_8;
      rsv_reg  <= 1'b0;
    end else begin
      bits_reg <= bits_next;
      step_reg <= step_next;
      rsv_reg  <= rsv_next;
    end
  end

  assign result_bits_o    = bits_reg;
  assign step_mv_o        = step_reg;
  assign width_reserved_o = rsv_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_width_ten;
    (width_code_i == 2'h1) |=> (result_bits_o == 4'hA && step_mv_o == 5'h05);
  endproperty
  a_width_ten: assert property (p_width_ten)
    else $error("10-bit width or 5 mV step wrong");

  property p_width_eight;
    (width_code_i == 2'h0) |=>
      (result_bits_o == 4'h8 && step_mv_o == 5'h14 && !width_reserved_o);
  endproperty
  a_width_eight: assert property (p_width_eight)
    else $error("8-bit width or 20 mV step wrong");

  c_ten_bit: cover property (width_code_i == 2'h1 ##1 result_bits_o == 4'hA);

endmodule : result_format
`default_nettype wire

// ---- adc_trigger_resolution_config.sv ----
// Trigger source, resolution and discharge configuration registers
//
// Function
// - Control register writes abort running sequence
// - Bit 7 picks analog or dedicated trigger
// - Select bit stored even without dedicated inputs
// - Channel codes 0-11 pick analog, above pick eleven
// - Codes 0-3 pick dedicated inputs, rest reserved
// - Bits 6-5: 8-bit, 10-bit, others reserved
// - Bit 4 discharges capacitor, adds two cycles
// - Step is 20 mV or 5 mV
// - Both registers read and written any time
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_resolution_config #(
  parameter bit EXT_TRIG_PRESENT = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic [11:0] analog_trig_i,
  input  wire logic [3:0]  ext_trigger_in_i,
  output logic             trig_level_o,
  output logic             trig_event_o,
  output logic             trig_src_reserved_o,
  output logic             abort_o,
  output logic             presample_discharge_o,
  output logic      [3:0]  sample_extra_cycles_o,
  output logic      [3:0]  result_bits_o,
  output logic      [4:0]  step_mv_o,
  output logic             width_reserved_o,
  output logic      [7:0]  conv_ctrl_two_o
);

  logic [7:0] conv_ctrl_one_reg;
  logic [7:0] conv_ctrl_one_next;
  logic [7:0] conv_ctrl_two_reg;
  logic [7:0] conv_ctrl_two_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       abort_reg;
  logic       level_d_reg;
  logic       event_reg;
  logic [3:0] extra_reg;
  logic       hit_one;
  logic       hit_two;
  logic       wr_one;
  logic       wr_two;
  logic       wr_ctrl;
  logic [7:0] status_val;
  logic [7:0] read_mux;
  logic       width_rsv;

  trig_sel_if tsel ();

  // Register decode
  assign hit_one = (addr_i == adc_cfg_pkg::CTRL_ONE_OFS);
  assign hit_two = (addr_i == adc_cfg_pkg::CTRL_TWO_OFS);
  assign wr_one  = wr_i & hit_one;
  assign wr_two  = wr_i & hit_two;
  assign wr_ctrl = wr_one | wr_two;

  assign conv_ctrl_one_next = wr_one ? wdata_i : conv_ctrl_one_reg;
  assign conv_ctrl_two_next = wr_two ? wdata_i : conv_ctrl_two_reg;

  // Status shows live trigger and decode state
  assign status_val = {4'h0,
                       tsel.ext_active,
                       width_rsv,
                       tsel.reserved,
                       tsel.level};

  // Unmapped addresses read as zero
  assign read_mux =
    hit_one ? conv_ctrl_one_reg :
    hit_two ? conv_ctrl_two_reg :
    (addr_i == adc_cfg_pkg::STATUS_OFS) ? status_val :
    adc_cfg_pkg::RDATA_IDLE;
  // Data only in the cycle after the strobe, zero otherwise
  assign rdata_next = rd_i ? read_mux : adc_cfg_pkg::RDATA_IDLE;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      conv_ctrl_one_reg <= adc_cfg_pkg::CTRL_ONE_RST;
      conv_ctrl_two_reg <= adc_cfg_pkg::CTRL_TWO_RST;
      rdata_reg         <= adc_cfg_pkg::RDATA_IDLE;
      abort_reg         <= 1'b0;
    end else begin
      conv_ctrl_one_reg <= conv_ctrl_one_next;
      conv_ctrl_two_reg <= conv_ctrl_two_next;
      rdata_reg         <= rdata_next;
      // Any control register write aborts, even one that rewrites the same value
      abort_reg         <= wr_ctrl;
    end
  end

  // Trigger source selection
  assign tsel.src_sel  = conv_ctrl_one_reg[adc_cfg_pkg::TRIG_SRC_BIT];
  assign tsel.chan_sel =
    conv_ctrl_one_reg[adc_cfg_pkg::CHAN_HI_BIT:adc_cfg_pkg::CHAN_LO_BIT];

  trig_source_mux #(
    .EXT_TRIG_PRESENT (EXT_TRIG_PRESENT)
  ) u_mux (
    .clk_i            (clk_i),
    .rst_b_i          (rst_b_i),
    .analog_trig_i    (analog_trig_i),
    .ext_trigger_in_i (ext_trigger_in_i),
    .sel              (tsel)
  );

  // Rising edge of the chosen source; a source switch can look like an edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      level_d_reg <= 1'b0;
      event_reg   <= 1'b0;
    end else begin
      level_d_reg <= tsel.level;
      event_reg   <= tsel.level & ~level_d_reg & ~wr_ctrl;
    end
  end

  // Sample phase lengthening for the discharge option
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      extra_reg <= adc_cfg_pkg::NO_EXTRA;
    end else begin
      extra_reg <= conv_ctrl_one_next[adc_cfg_pkg::DISCH_BIT] ?
                   adc_cfg_pkg::DISCH_EXTRA : adc_cfg_pkg::NO_EXTRA;
    end
  end

  result_format u_fmt (
    .clk_i            (clk_i),
    .rst_b_i          (rst_b_i),
    .width_code_i     (conv_ctrl_one_reg[adc_cfg_pkg::WIDTH_HI_BIT:
                                         adc_cfg_pkg::WIDTH_LO_BIT]),
    .result_bits_o    (result_bits_o),
    .step_mv_o        (step_mv_o),
    .width_reserved_o (width_rsv)
  );

  assign rdata_o               = rdata_reg;
  assign abort_o               = abort_reg;
  assign trig_level_o          = tsel.level;
  assign trig_event_o          = event_reg;
  assign trig_src_reserved_o   = tsel.reserved;
  assign presample_discharge_o =
    conv_ctrl_one_reg[adc_cfg_pkg::DISCH_BIT];
  assign sample_extra_cycles_o = extra_reg;
  assign width_reserved_o      = width_rsv;
  assign conv_ctrl_two_o       = conv_ctrl_two_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_abort_on_write;
    (wr_i && (addr_i == 8'h01 || addr_i == 8'h02)) |=> abort_o;
  endproperty
  a_abort_on_write: assert property (p_abort_on_write)
    else $error("control write did not abort");

  property p_abort_cause;
    abort_o |-> $past(wr_i) && ($past(addr_i) == 8'h01 ||
                                $past(addr_i) == 8'h02);
  endproperty
  a_abort_cause: assert property (p_abort_cause)
    else $error("abort without control write");

  property p_select_stored;
    (wr_i && addr_i == 8'h01) |=> conv_ctrl_one_reg == $past(wdata_i);
  endproperty
  a_select_stored: assert property (p_select_stored)
    else $error("control one write not stored");

  property p_src_follows;
    tsel.ext_active == (EXT_TRIG_PRESENT && conv_ctrl_one_reg[7]);
  endproperty
  a_src_follows: assert property (p_src_follows)
    else $error("source select not taken from bit 7");

  property p_discharge;
    (wr_i && addr_i == 8'h01) |=>
      presample_discharge_o == $past(wdata_i[4]) &&
      sample_extra_cycles_o == ($past(wdata_i[4]) ? 4'h2 : 4'h0);
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("discharge bit or extra cycles wrong");

  property p_read_back;
    (rd_i && addr_i == 8'h02) |=> rdata_o == $past(conv_ctrl_two_reg)
                                  ##1 (rdata_o == 8'h00 || $past(rd_i));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("control two read back wrong");

  property p_reset_zero;
    @(posedge clk_i) disable iff (1'b0)
      !rst_b_i |=> conv_ctrl_one_reg == 8'h00 && conv_ctrl_two_reg == 8'h00
                   && !abort_o && rdata_o == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

  // Abort is one cycle wide unless writes come back to back
  property p_abort_single;
    (abort_o && !wr_ctrl) |=> !abort_o;
  endproperty
  a_abort_single: assert property (p_abort_single)
    else $error("abort held beyond its write");

  property p_two_stored;
    (wr_i && addr_i == 8'h02) |=> conv_ctrl_two_o == $past(wdata_i);
  endproperty
  a_two_stored: assert property (p_two_stored)
    else $error("control two write not stored");

  property p_one_held;
    !(wr_i && addr_i == 8'h01) |=> $stable(conv_ctrl_one_reg);
  endproperty
  a_one_held: assert property (p_one_held)
    else $error("control one changed without its write");

  property p_two_held;
    !(wr_i && addr_i == 8'h02) |=> $stable(conv_ctrl_two_o);
  endproperty
  a_two_held: assert property (p_two_held)
    else $error("control two changed without its write");

  property p_read_one;
    (rd_i && addr_i == 8'h01) |=> rdata_o == $past(conv_ctrl_one_reg);
  endproperty
  a_read_one: assert property (p_read_one)
    else $error("control one read back wrong");

  property p_read_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside a read");

  // Status is a snapshot taken at the strobe edge
  property p_status_read;
    (rd_i && addr_i == 8'h03) |=>
      rdata_o == {4'h0, $past(tsel.ext_active), $past(width_reserved_o),
                  $past(trig_src_reserved_o), $past(trig_level_o)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");

  property p_event_rise;
    trig_event_o |->
      $past(trig_level_o) && !$past(trig_level_o, 2) && !$past(wr_ctrl);
  endproperty
  a_event_rise: assert property (p_event_rise)
    else $error("trigger event without a rising level");

  property p_event_follows;
    ($rose(trig_level_o) && !wr_ctrl) |=> trig_event_o;
  endproperty
  a_event_follows: assert property (p_event_follows)
    else $error("rising trigger level gave no event");

  property p_event_quiet;
    wr_ctrl |=> !trig_event_o;
  endproperty
  a_event_quiet: assert property (p_event_quiet)
    else $error("trigger event during a control write");

  property p_extra_tracks;
    sample_extra_cycles_o == (presample_discharge_o ? 4'h2 : 4'h0);
  endproperty
  a_extra_tracks: assert property (p_extra_tracks)
    else $error("extra cycles disagree with discharge bit");

  property p_width_rsv_tracks;
    width_reserved_o == $past(conv_ctrl_one_reg[6]);
  endproperty
  a_width_rsv_tracks: assert property (p_width_rsv_tracks)
    else $error("reserved width flag wrong");

  property p_rsv_level;
    trig_src_reserved_o |-> !trig_level_o;
  endproperty
  a_rsv_level: assert property (p_rsv_level)
    else $error("reserved trigger code gave a level");

  property p_step_pair;
    (result_bits_o == 4'hA) == (step_mv_o == 5'h05);
  endproperty
  a_step_pair: assert property (p_step_pair)
    else $error("step size does not match result width");

  c_abort: cover property (wr_i && addr_i == 8'h02 ##1 abort_o);
  c_event: cover property (trig_event_o);
  c_discharge: cover property (sample_extra_cycles_o == 4'h2);

endmodule : adc_trigger_resolution_config
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the trigger, resolution and discharge registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_i   = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr_i  = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [11:0] an_pins = 12'h000;
  logic [3:0]  ex_pins = 4'h0;
  logic [7:0]  rdata;
  logic [7:0]  rdata_nx;
  logic        level;
  logic        level_nx;
  logic        event_p;
  logic        src_rsv;
  logic        abort;
  logic        disch;
  logic [3:0]  extra;
  logic [3:0]  bits;
  logic [4:0]  step;
  logic        wrsv;
  logic [7:0]  two;
  int          bad_count = 0;
  int          n_checks  = 0;

  adc_trigger_resolution_config #(.EXT_TRIG_PRESENT(1'b1)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .analog_trig_i(an_pins),
    .ext_trigger_in_i(ex_pins), .trig_level_o(level), .trig_event_o(event_p),
    .trig_src_reserved_o(src_rsv), .abort_o(abort),
    .presample_discharge_o(disch), .sample_extra_cycles_o(extra),
    .result_bits_o(bits), .step_mv_o(step), .width_reserved_o(wrsv),
    .conv_ctrl_two_o(two));

  // Same bus, but built without the dedicated trigger inputs
  adc_trigger_resolution_config #(.EXT_TRIG_PRESENT(1'b0)) dut_noext (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_nx), .analog_trig_i(an_pins),
    .ext_trigger_in_i(ex_pins), .trig_level_o(level_nx), .trig_event_o(),
    .trig_src_reserved_o(), .abort_o(), .presample_discharge_o(),
    .sample_extra_cycles_o(), .result_bits_o(), .step_mv_o(),
    .width_reserved_o(), .conv_ctrl_two_o());

  always #5 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Returns just after the edge that took the write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data are valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [7:0] d_nx);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d    = rdata;
    d_nx = rdata_nx;
  endtask : rd

  function automatic logic exp_level(input logic s, input logic [3:0] c,
      input logic [11:0] a, input logic [3:0] e, input logic pres);
    if (s && pres)
      return (c[3] | c[2]) ? 1'b0 : e[c[1:0]];
    return a[(c > 4'hB) ? 4'hB : c];
  endfunction : exp_level

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  initial begin
    logic [7:0]  d;
    logic [7:0]  r;
    logic [7:0]  r_nx;
    logic [3:0]  c;
    logic        s;
    logic        e0;
    logic        e1;
    logic [7:0]  ev;
    void'($urandom(32'hBBC7));
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk("reset bits", 8'h08, {4'h0, bits});
    chk("reset step", 8'h14, {3'h0, step});
    chk("reset extra", 8'h00, {3'h0, disch, extra});
    chk("reset two", 8'h00, two);
    rd(8'h01, r, r_nx);
    chk("reset one", 8'h00, r);
    rd(8'h02, r, r_nx);
    chk("reset two rd", 8'h00, r);
    // Unmapped place: no abort, reads as zero
    wr(8'h05, 8'hFF);
    chk("unmapped abort", 8'h00, {7'h0, abort});
    rd(8'h05, r, r_nx);
    chk("unmapped rd", 8'h00, r);
    // Random control writes, every width code among them
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom());
      if (i < 8)
        d[6:5] = i[2:1];
      if (i[0]) begin
        wr(8'h02, d);
        chk("abort two", 8'h01, {7'h0, abort});
        chk("two out", d, two);
        rd(8'h02, r, r_nx);
        chk("two rd", d, r);
      end else begin
        wr(8'h01, d);
        chk("abort one", 8'h01, {7'h0, abort});
        chk("discharge", {7'h0, d[4]}, {7'h0, disch});
        chk("extra", d[4] ? 8'h02 : 8'h00, {4'h0, extra});
        @(posedge clk_i);
        #1;
        chk("abort drop", 8'h00, {7'h0, abort});
        chk("bits", (d[6:5] == 2'b01) ? 8'h0A : 8'h08, {4'h0, bits});
        chk("step", (d[6:5] == 2'b01) ? 8'h05 : 8'h14, {3'h0, step});
        chk("width rsv", {7'h0, d[6]}, {7'h0, wrsv});
        rd(8'h01, r, r_nx);
        chk("one rd", d, r);
        chk("rd no abort", 8'h00, {7'h0, abort});
      end
    end
    // Every source and channel code, both pin polarities
    for (int k = 0; k < 32; k++) begin
      s = k[4];
      c = k[3:0];
      wr(8'h01, {s, 3'b000, c});
      @(posedge clk_i);
      an_pins <= 12'($urandom());
      ex_pins <= 4'($urandom());
      repeat (5) @(posedge clk_i);
      #1;
      e0 = exp_level(s, c, an_pins, ex_pins, 1'b1);
      chk("level", {7'h0, e0}, {7'h0, level});
      chk("level noext", {7'h0, exp_level(s, c, an_pins, ex_pins, 1'b0)},
          {7'h0, level_nx});
      chk("src rsv", {7'h0, s & (c[3] | c[2])}, {7'h0, src_rsv});
      rd(8'h03, r, r_nx);
      chk("status", {4'h0, s, 1'b0, s & (c[3] | c[2]), e0}, r);
      rd(8'h01, r, r_nx);
      chk("sel kept", {s, 3'b000, c}, r);
      chk("sel stored", {s, 3'b000, c}, r_nx);
      @(posedge clk_i);
      an_pins <= ~an_pins;
      ex_pins <= ~ex_pins;
      ev = 8'h00;
      repeat (6) begin
        @(posedge clk_i);
        #1;
        if (event_p === 1'b1)
          ev++;
      end
      e1 = exp_level(s, c, an_pins, ex_pins, 1'b1);
      chk("level flip", {7'h0, e1}, {7'h0, level});
      chk("events", {7'h0, ~e0 & e1}, ev);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
